/* src/record_parser.sv */
// collects 12-byte settings records of the sync config command
`timescale 1ns/1ns
module record_parser (
  input wire logic clk,
  input wire logic nrst,
  input wire logic msgStart,
  input wire logic [7:0] msgId,
  input wire logic byteValid,
  input wire logic [7:0] byteIn,
  sync_cfg_if.src cfg
);
  import sync_trig_pkg::*;

  logic [7:0] recBuf_r [0:REC_BYTES-1];
  logic [3:0] idx_r;
  logic [7:0] mid_r;

  // ==========================================================
  // decode
  wire lastByte = byteValid && (idx_r == REC_LAST);
  wire isSyncCmd = (mid_r == CMD_SYNC_CONFIG);
  wire recUsable = (recBuf_r[OFS_FUNC] == FUNC_SEND_LATEST)
                && (recBuf_r[OFS_LINE] == LINE_SYNC_IN);
  wire takeRec = lastByte && isSyncCmd && recUsable;

  // ==========================================================
  // byte store, no reset needed
  always_ff @(posedge clk) begin
    if (byteValid) begin
      recBuf_r[idx_r] <= byteIn;
    end
  end

  // a full record is applied only with send latest function and sync line, index wraps for the next
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx_r <= 4'h0;
      mid_r <= 8'h00;
      cfg.apply <= 1'b0;
      cfg.polarity <= 8'h00;
      cfg.skipFirst <= 16'h0000;
      cfg.skipFactor <= 16'h0000;
      cfg.delay <= 16'h0000;
    end else begin
      cfg.apply <= takeRec;
      if (msgStart) begin
        mid_r <= msgId;
        idx_r <= 4'h0;
      end else if (byteValid) begin
        idx_r <= lastByte ? 4'h0 : idx_r + 4'h1;
      end
      // bytes 3, 8 and 9 are never looked at
      if (takeRec) begin
        cfg.polarity <= recBuf_r[OFS_POL];
        cfg.skipFirst <= {recBuf_r[OFS_SKIP_FIRST], recBuf_r[OFS_SKIP_FIRST+1]};
        cfg.skipFactor <= {recBuf_r[OFS_SKIP_FACTOR], recBuf_r[OFS_SKIP_FACTOR+1]};
        cfg.delay <= {recBuf_r[OFS_DELAY], byteIn};
      end
    end
  end

  // ==========================================================
  // checks
  AST_REC_APPLY: assert property (@(posedge clk) disable iff (!nrst)
    cfg.apply |-> $past(byteValid) && $past(idx_r) == REC_LAST
      && $past(mid_r) == CMD_SYNC_CONFIG)
    else $error("settings applied without a full sync config record");
  AST_REC_FILTER: assert property (@(posedge clk) disable iff (!nrst)
    (lastByte && isSyncCmd && recBuf_r[OFS_FUNC] != FUNC_SEND_LATEST) |=> !cfg.apply)
    else $error("record with other function was applied");
endmodule : record_parser

/* src/sync_cfg_if.sv */
// settings carried from the record parser to the trigger
`timescale 1ns/1ns
interface sync_cfg_if;
  logic apply;
  logic [7:0] polarity;
  logic [15:0] skipFirst;
  logic [15:0] skipFactor;
  logic [15:0] delay;
  modport src (output apply, polarity, skipFirst, skipFactor, delay);
  modport dst (input apply, polarity, skipFirst, skipFactor, delay);
endinterface : sync_cfg_if

/* src/sync_edge_detect.sv */
// synchronises the sync input and picks the configured edges
`timescale 1ns/1ns
module sync_edge_detect (
  input wire logic clk,
  input wire logic nrst,
  input wire logic syncIn,
  input wire logic [7:0] polarity,
  output logic evt
);
  import sync_trig_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  // ==========================================================
  // edge select
  wire rise = sync2_r && !sync3_r;
  wire fall = !sync2_r && sync3_r;
  wire selRise = (polarity == POL_RISE) || (polarity == POL_BOTH);
  wire selFall = (polarity == POL_FALL) || (polarity == POL_BOTH);
  assign evt = (selRise && rise) || (selFall && fall);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= syncIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ==========================================================
  // checks
  AST_EDGE_POL: assert property (@(posedge clk) disable iff (!nrst)
    (polarity == POL_RISE && fall) |-> !evt)
    else $error("falling edge counted under rising polarity");
  AST_SYNC_LAT: assert property (@(posedge clk) disable iff (!nrst)
    rise |-> $past(syncIn, 2) && !$past(syncIn, 3))
    else $error("edge does not follow sync input by two cycles");
endmodule : sync_edge_detect

/* src/sync_input_event_trigger.sv */
// top: bus slave, skip counters, delay timer and latest-data output
`timescale 1ns/1ns
// Behaviour
// - command 0x2C carries 12-byte records, applied when byte0 and byte1 match
// - byte0 8 send latest, byte1 2 sync
// - byte2 picks rising, falling or both edges
// - skip first count at bytes 4-5
// - skip factor at bytes 6-7 after actions
// - delay at bytes 10-11 in 100us
// - bytes 3, 8, 9 are ignored
// - fire sends latest data, sampling keeps running
module sync_input_event_trigger (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic syncIn,
  input wire logic [31:0] sampleData,
  input wire logic sampleValid,
  output logic [31:0] txData,
  output logic txValid
);
  import sync_trig_pkg::*;

  // ==========================================================
  // bus state
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic msgStart_r;
  logic byteValid_r;
  logic [7:0] msgByte_r;

  // ==========================================================
  // trigger state
  trig_state_t state_r;
  logic [7:0] pol_r;
  logic [15:0] factor_r;
  logic [15:0] delay_r;
  logic [15:0] skip_r;
  logic [15:0] unit_r;
  logic [11:0] pre_r;
  logic fire_r;
  logic [15:0] eventCnt_r;
  logic [31:0] fireCnt_r;
  logic [31:0] latest_r;
  logic [31:0] txData_r;
  logic txValid_r;
  logic evt;

  sync_cfg_if cfg ();

  // ==========================================================
  // submodules
  record_parser u_parser (
    .clk(clk),
    .nrst(nrst),
    .msgStart(msgStart_r),
    .msgId(msgByte_r),
    .byteValid(byteValid_r),
    .byteIn(msgByte_r),
    .cfg(cfg.src)
  );

  sync_edge_detect u_edge (
    .clk(clk),
    .nrst(nrst),
    .syncIn(syncIn),
    .polarity(pol_r),
    .evt(evt)
  );

  // ==========================================================
  // write channel decode
  wire awTake = s_axi_awvalid && awready_r;
  wire wTake = s_axi_wvalid && wready_r;
  wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
  wire wrMsg = (awAddr_r == ADDR_MSG_ID);
  wire wrPay = (awAddr_r == ADDR_PAYLOAD);
  wire wrMapped = wrMsg || wrPay;
  wire awHeldNxt = doWrite ? 1'b0 : (awHeld_r || awTake);
  wire wHeldNxt = doWrite ? 1'b0 : (wHeld_r || wTake);
  wire bvalidNxt = doWrite || (bvalid_r && !s_axi_bready);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      awHeld_r <= awHeldNxt;
      wHeld_r <= wHeldNxt;
      awready_r <= !awHeldNxt && !bvalidNxt;
      wready_r <= !wHeldNxt && !bvalidNxt;
      bvalid_r <= bvalidNxt;
      if (doWrite) begin
        bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (awTake) begin
      awAddr_r <= s_axi_awaddr;
    end
    if (wTake) begin
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
  end

  // command bytes to the parser, low byte lane only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      msgStart_r <= 1'b0;
      byteValid_r <= 1'b0;
      msgByte_r <= 8'h00;
    end else begin
      msgStart_r <= doWrite && wrMsg && wStrb_r[0];
      byteValid_r <= doWrite && wrPay && wStrb_r[0];
      if (doWrite) begin
        msgByte_r <= wData_r[7:0];
      end
    end
  end

  // ==========================================================
  // read channel decode
  wire arTake = s_axi_arvalid && arready_r;
  wire rvalidNxt = arTake || (rvalid_r && !s_axi_rready);
  wire [31:0] statusWord = {13'h0000, state_r, eventCnt_r};
  wire [31:0] skipWord = {factor_r, skip_r};
  wire [31:0] delayWord = {8'h00, pol_r, delay_r};
  wire rdStatus = (s_axi_araddr == ADDR_STATUS);
  wire rdSkip = (s_axi_araddr == ADDR_SKIP);
  wire rdDelay = (s_axi_araddr == ADDR_DELAY);
  wire rdFire = (s_axi_araddr == ADDR_FIRE_CNT);
  wire rdLatest = (s_axi_araddr == ADDR_LATEST);
  wire rdWo = (s_axi_araddr == ADDR_MSG_ID) || (s_axi_araddr == ADDR_PAYLOAD);
  wire rdMapped = rdStatus || rdSkip || rdDelay || rdFire || rdLatest || rdWo;
  wire [31:0] rdMux = rdStatus ? statusWord :
                      rdSkip ? skipWord :
                      rdDelay ? delayWord :
                      rdFire ? fireCnt_r :
                      rdLatest ? latest_r : DATA_RESET;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= DATA_RESET;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= !rvalidNxt;
      rvalid_r <= rvalidNxt;
      if (arTake) begin
        rdata_r <= rdMux;
        rresp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // trigger decode
  wire armedEvt = (state_r == ST_ARMED) && evt && !cfg.apply;
  wire skipDone = (skip_r == 16'h0000);
  wire actNow = armedEvt && skipDone && (delay_r == 16'h0000);
  wire startDelay = armedEvt && skipDone && (delay_r != 16'h0000);
  wire preDone = (state_r == ST_DELAY) && (pre_r == 12'h000) && !cfg.apply;
  wire delayDone = preDone && (unit_r == 16'h0001);
  wire fireNow = actNow || delayDone;
  wire [15:0] delayClamp = (cfg.delay > DELAY_MAX) ? DELAY_MAX : cfg.delay;

  // skip counters first, then the delay timer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      pol_r <= 8'h00;
      factor_r <= 16'h0000;
      delay_r <= 16'h0000;
      skip_r <= 16'h0000;
      unit_r <= 16'h0000;
      pre_r <= 12'h000;
    end else if (cfg.apply) begin
      state_r <= ST_ARMED;
      pol_r <= cfg.polarity;
      factor_r <= cfg.skipFactor;
      delay_r <= delayClamp;
      skip_r <= cfg.skipFirst;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_r <= ST_IDLE;
        end
        ST_ARMED: begin
          if (armedEvt && !skipDone) begin
            skip_r <= skip_r - 16'h0001;
          end else if (actNow) begin
            skip_r <= factor_r;
          end else if (startDelay) begin
            state_r <= ST_DELAY;
            unit_r <= delay_r;
            pre_r <= UNIT_CYCLES - 12'h001;
          end
        end
        ST_DELAY: begin
          if (delayDone) begin
            state_r <= ST_ARMED;
            skip_r <= factor_r;
          end else if (preDone) begin
            unit_r <= unit_r - 16'h0001;
            pre_r <= UNIT_CYCLES - 12'h001;
          end else begin
            pre_r <= pre_r - 12'h001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // event and fire counters, latest data
  wire [31:0] latestNow = sampleValid ? sampleData : latest_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fire_r <= 1'b0;
      eventCnt_r <= 16'h0000;
      fireCnt_r <= DATA_RESET;
      latest_r <= DATA_RESET;
      txData_r <= DATA_RESET;
      txValid_r <= 1'b0;
    end else begin
      fire_r <= fireNow;
      if (evt) begin
        eventCnt_r <= eventCnt_r + 16'h0001;
      end
      if (fireNow) begin
        fireCnt_r <= fireCnt_r + 32'h0000_0001;
      end
      latest_r <= latestNow;
      txValid_r <= fireNow;
      if (fireNow) begin
        txData_r <= latestNow;
      end
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign txData = txData_r;
  assign txValid = txValid_r;

  // ==========================================================
  // checks
  AST_SKIP_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    cfg.apply |=> (skip_r == $past(cfg.skipFirst)) && (state_r == ST_ARMED))
    else $error("skip first count not loaded on apply");
  AST_SKIP_COUNT: assert property (@(posedge clk) disable iff (!nrst)
    (armedEvt && !skipDone) |=> (skip_r == $past(skip_r) - 16'h0001) && !fire_r)
    else $error("skipped event did not count down");
  AST_SKIP_RELOAD: assert property (@(posedge clk) disable iff (!nrst)
    (fire_r && !cfg.apply) |-> (skip_r == factor_r) && (state_r == ST_ARMED))
    else $error("skip factor not reloaded after action");
  AST_DELAY_UNIT: assert property (@(posedge clk) disable iff (!nrst)
    (preDone && !delayDone) |=> (pre_r == UNIT_CYCLES - 12'h001)
      && (unit_r == $past(unit_r) - 16'h0001))
    else $error("delay unit is not 2500 cycles");
  AST_ZERO_DELAY: assert property (@(posedge clk) disable iff (!nrst)
    actNow |=> fire_r && txValid_r)
    else $error("zero delay action did not fire at once");
  AST_FIRE_OUT: assert property (@(posedge clk) disable iff (!nrst)
    txValid_r |-> (txData_r == $past(latestNow)) && fire_r)
    else $error("sent data is not the latest sample");
endmodule : sync_input_event_trigger

/* src/sync_trig_pkg.sv */
// constants and types of the sync input event trigger
package sync_trig_pkg;
  // ==========================================================
  // command and record layout
  localparam logic [7:0] CMD_SYNC_CONFIG = 8'h2C;
  localparam logic [7:0] FUNC_SEND_LATEST = 8'h08;
  localparam logic [7:0] LINE_SYNC_IN = 8'h02;
  localparam logic [7:0] POL_RISE = 8'h01;
  localparam logic [7:0] POL_FALL = 8'h02;
  localparam logic [7:0] POL_BOTH = 8'h03;
  localparam int REC_BYTES = 12;
  localparam logic [3:0] REC_LAST = 4'hB;
  localparam int OFS_FUNC = 0;
  localparam int OFS_LINE = 1;
  localparam int OFS_POL = 2;
  localparam int OFS_SKIP_FIRST = 4;
  localparam int OFS_SKIP_FACTOR = 6;
  localparam int OFS_DELAY = 10;
  localparam logic [15:0] DELAY_MAX = 16'hEA60;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int DELAY_UNIT_NS = 100000;
  localparam int UNIT_CYCLES_INT = DELAY_UNIT_NS / (1000000000 / CLK_HZ);
  localparam logic [11:0] UNIT_CYCLES = 12'(UNIT_CYCLES_INT);
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_MSG_ID = 8'h00;
  localparam logic [7:0] ADDR_PAYLOAD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SKIP = 8'h0C;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_FIRE_CNT = 8'h14;
  localparam logic [7:0] ADDR_LATEST = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  // ==========================================================
  // trigger states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_DELAY = 3'b100
  } trig_state_t;
endpackage : sync_trig_pkg

/* testbench/sync_source_model.sv */
// sync pulse source and sample stream model
`timescale 1ns/1ns
module sync_source_model (
  input wire logic clk,
  input wire logic pulseReq,
  input wire logic [31:0] sampleVal,
  output logic syncIn,
  output logic [31:0] sampleData,
  output logic sampleValid
);
  logic [3:0] hold;
  initial begin
    syncIn = 1'b0;
    hold = 4'h0;
    sampleData = 32'h0;
    sampleValid = 1'b0;
  end
  // ==========================================================
  // pulse source, idle low between pulses
  always @(posedge clk) begin
    if (pulseReq) hold <= 4'h8;
    else if (hold != 4'h0) hold <= hold - 4'h1;
    syncIn <= pulseReq || (hold > 4'h1);
  end
  // ==========================================================
  // sample stream keeps running
  always @(posedge clk) begin
    sampleData <= sampleVal;
    sampleValid <= 1'b1;
  end
endmodule : sync_source_model

/* testbench/test_sync_input_event_trigger.sv */
// self-checking bench of the sync input event trigger
`timescale 1ns/1ns
module test_sync_input_event_trigger;
  import sync_trig_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, pulseReq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, sampleVal, rnd;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, syncIn, sampleValid, txValid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, sampleData, txData;
  logic [31:0] expQ[$];
  int mismatches, cmpCount, fires;
  sync_input_event_trigger DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .syncIn(syncIn), .sampleData(sampleData),
    .sampleValid(sampleValid), .txData(txData), .txValid(txValid));
  sync_source_model partner (.clk(clk), .pulseReq(pulseReq), .sampleVal(sampleVal),
    .syncIn(syncIn), .sampleData(sampleData), .sampleValid(sampleValid));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (expQ.size() != 0) mismatches++;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    rnd = xs(rnd);
    @(posedge clk);
    awaddr <= a;
    wdata <= {rnd[31:8], d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check(rdata & m, e);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd
  task automatic rec(input logic [7:0] f, input logic [7:0] ln, input logic [7:0] pol,
                     input logic [15:0] s1, input logic [15:0] s2, input logic [15:0] dl);
    logic [95:0] r;
    rnd = xs(rnd);
    r = {f, ln, pol, rnd[7:0], s1, s2, rnd[23:8], dl};
    for (int i = 11; i >= 0; i--) wr(ADDR_PAYLOAD, r[i*8 +: 8], RESP_OKAY);
  endtask : rec
  task automatic msg(input logic [7:0] id);
    wr(ADDR_MSG_ID, id, RESP_OKAY);
  endtask : msg
  task automatic pulse(input int n);
    @(posedge clk);
    pulseReq <= 1'b1;
    repeat (n) expQ.push_back(sampleVal);
    fires += n;
    @(posedge clk);
    pulseReq <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : pulse
  // ==========================================================
  // clock, watchdog and output monitor
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  always @(posedge clk) begin
    if (txValid === 1'b1) check(txData, expQ.size() ? expQ.pop_front() : ~txData);
  end
  // ==========================================================
  // scenarios
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, pulseReq} = 7'h0;
    {awaddr, araddr, wstrb, wdata} = 52'h0;
    rnd = 32'hBB6449A8;
    sampleVal = 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_STATUS, 32'h0001_0000, ALL, RESP_OKAY);
    rd(8'h1C, 32'h0, ALL, RESP_SLVERR);
    wr(8'h40, 8'h5A, RESP_SLVERR);
    wr(ADDR_STATUS, 8'h00, RESP_SLVERR);
    pulse(0);
    msg(CMD_SYNC_CONFIG);
    rec(8'h07, LINE_SYNC_IN, POL_RISE, 16'h0, 16'h0, 16'h0005);
    rec(FUNC_SEND_LATEST, 8'h01, POL_RISE, 16'h0, 16'h0, 16'h0006);
    msg(8'h2D);
    rec(FUNC_SEND_LATEST, LINE_SYNC_IN, POL_RISE, 16'h0, 16'h0, 16'h0007);
    rd(ADDR_DELAY, 32'h0, ALL, RESP_OKAY);
    pulse(0);
    msg(CMD_SYNC_CONFIG);
    rec(FUNC_SEND_LATEST, LINE_SYNC_IN, POL_FALL, 16'h0, 16'h0, 16'h1234);
    rec(FUNC_SEND_LATEST, LINE_SYNC_IN, POL_RISE, 16'h0002, 16'h0001, 16'h0);
    rd(ADDR_DELAY, {8'h0, POL_RISE, 16'h0}, ALL, RESP_OKAY);
    rd(ADDR_SKIP, 32'h0001_0000, 32'hFFFF_0000, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0002_0000, 32'h0007_0000, RESP_OKAY);
    sampleVal <= xs(rnd);
    for (int k = 1; k <= 6; k++) pulse((k == 3 || k == 5) ? 1 : 0);
    for (int p = 1; p <= 3; p++) begin
      msg(CMD_SYNC_CONFIG);
      rec(FUNC_SEND_LATEST, LINE_SYNC_IN, 8'(p), 16'h0, 16'h0, 16'h0);
      rnd = xs(rnd);
      sampleVal <= rnd;
      pulse((p == 3) ? 2 : 1);
    end
    msg(CMD_SYNC_CONFIG);
    rec(FUNC_SEND_LATEST, LINE_SYNC_IN, POL_RISE, 16'h0, 16'h0, 16'h0001);
    pulse(1);
    repeat (2300) @(posedge clk);
    rd(ADDR_FIRE_CNT, 32'(fires - 1), ALL, RESP_OKAY);
    repeat (300) @(posedge clk);
    rd(ADDR_FIRE_CNT, 32'(fires), ALL, RESP_OKAY);
    pulse(0);
    msg(CMD_SYNC_CONFIG);
    rec(FUNC_SEND_LATEST, LINE_SYNC_IN, POL_RISE, 16'h0, 16'h0, 16'hFFFF);
    rd(ADDR_DELAY, {8'h0, POL_RISE, DELAY_MAX}, ALL, RESP_OKAY);
    repeat (2600) @(posedge clk);
    rd(ADDR_FIRE_CNT, 32'(fires), ALL, RESP_OKAY);
    rd(ADDR_LATEST, sampleVal, ALL, RESP_OKAY);
    end_of_test();
  end
endmodule : test_sync_input_event_trigger
